// File: logic/fault_responder.sv
`timescale 1ns/1ps
// shuts the output off on a fault, then retries or waits for a rearm
module fault_responder #(
  parameter int RETRY_CYC = 16250000
) (
  input  wire logic i_clk,    // system clock
  input  wire logic i_rst_n,  // synchronised reset, active low
  input  wire logic i_fault,  // qualified fault level
  input  wire logic i_latch,  // 1: latching response
  input  wire logic i_rearm,  // explicit re-enable pulse
  output logic      o_off,    // hold output off
  output logic      o_trip    // one-cycle trip pulse
);
  localparam int CW = $clog2(RETRY_CYC + 1);

  typedef enum logic [1:0] {
    S_RUN   = 2'b00,
    S_RETRY = 2'b01,
    S_HOLD  = 2'b10
  } state_e;

  typedef struct packed {
    state_e        state;
    logic [CW-1:0] cnt;
    logic          trip;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.trip = 1'b0;
    case (st_ff.state)
      S_RUN:
        if (i_fault)
        begin
          nxt_st.trip  = 1'b1;
          nxt_st.cnt   = '0;
          nxt_st.state = i_latch ? S_HOLD : S_RETRY;
        end
      S_RETRY:
        if (st_ff.cnt == CW'(RETRY_CYC - 1))
          nxt_st.state = S_RUN;
        else
          nxt_st.cnt = st_ff.cnt + CW'(1);
      S_HOLD:
        if (i_rearm)
          nxt_st.state = S_RUN;
      default:
        nxt_st.state = S_RUN;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_ff <= '{state: S_RUN, cnt: '0, trip: 1'b0};
    else
      st_ff <= nxt_st;
  end

  assign o_off  = (st_ff.state != S_RUN);
  assign o_trip = st_ff.trip;
endmodule // fault_responder

// File: logic/fault_sup_pkg.sv
package fault_sup_pkg;

  // clock rate and protection timing
  localparam int CLK_MHZ        = 125;
  localparam int FAULT_DLY_NS   = 6000;   // 6 us qualification delay
  localparam int FAULT_DLY_CYC  = FAULT_DLY_NS * CLK_MHZ / 1000;
  localparam int OT_DLY_MS      = 2;      // overtemperature turn-off delay
  localparam int OT_DLY_CYC     = OT_DLY_MS * CLK_MHZ * 1000;
  localparam int RETRY_MS       = 130;    // hiccup retry period
  localparam int RETRY_CYC      = RETRY_MS * CLK_MHZ * 1000;

  // apb register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_THRESH = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h10;

  // ctrl fields
  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_UV_LATCH    = 1;
  localparam int CTRL_OV_LATCH    = 2;
  localparam int CTRL_TRK_EN      = 3;
  localparam int CTRL_TRK_LATCH   = 4;
  localparam int CTRL_OT_LATCH    = 5;
  localparam int CTRL_W           = 6;
  localparam logic [5:0] CTRL_RST = 6'h01;  // on, all non-latching, no trk

  // thresh fields: uv sel [1:0], ov sel [5:4], pg sel [8]
  localparam int UV_SEL_LSB = 0;
  localparam int OV_SEL_LSB = 4;
  localparam int PG_SEL_BIT = 8;
  localparam logic [1:0] UV_SEL_RST = 2'h0;
  localparam logic [1:0] OV_SEL_RST = 2'h0;
  localparam logic       PG_SEL_RST = 1'h0;

  // interrupt event bits
  localparam int IRQ_W      = 6;
  localparam int EV_UV      = 0;
  localparam int EV_OV      = 1;
  localparam int EV_TRK     = 2;
  localparam int EV_OT      = 3;
  localparam int EV_WARN    = 4;
  localparam int EV_PG      = 5;
  localparam logic [5:0] IRQ_MASK_RST = 6'h00;

  // thresholds in percent of setpoint, millivolts, degrees C
  localparam logic [7:0]  UV_BASE_PCT = 8'h4B;  // 75
  localparam logic [7:0]  UV_STEP_PCT = 8'h05;
  localparam logic [7:0]  OV_BASE_PCT = 8'h82;  // 130
  localparam logic [7:0]  OV_STEP_PCT = 8'h0A;
  localparam logic [7:0]  OV_MIN_PCT  = 8'h6E;  // 110
  localparam logic [7:0]  PG_LO_PCT   = 8'h5A;  // 90
  localparam logic [7:0]  PG_STEP_PCT = 8'h05;
  localparam logic [7:0]  PG_HI_PCT   = 8'h6E;  // 110
  localparam logic [15:0] OV_FLOOR_MV = 16'h03E8; // 1.0 V
  localparam logic [15:0] TRK_BAND_MV = 16'h00FA; // 250 mV
  localparam logic signed [7:0] OT_OFF_C  = 8'sh78; // 120 C
  localparam logic signed [7:0] OT_ON_C   = 8'sh6E; // 110 C
  localparam logic signed [7:0] WARN_CLR_C = 8'sh75; // 117 C

  // percentage of a millivolt value, truncated
  function automatic logic [15:0] pct_of(input logic [15:0] mv,
                                         input logic [7:0]  pct);
    logic [23:0] prod;
    prod = {8'h00, mv} * {16'h0000, pct};
    return 16'(prod / 24'h000064);
  endfunction

endpackage

// File: logic/output_fault_supervisor.sv
`timescale 1ns/1ps
module output_fault_supervisor #(
  parameter int OT_DLY_CYC = fault_sup_pkg::OT_DLY_CYC,
  parameter int RETRY_CYC  = fault_sup_pkg::RETRY_CYC
) (
  input  wire logic              I_CLK_SYS,   // 125 mhz system clock
  input  wire logic              I_RESET_N,   // async reset, active low
  input  wire logic              I_PSEL,      // apb select
  input  wire logic              I_PENABLE,   // apb access phase
  input  wire logic              I_PWRITE,    // apb write
  input  wire logic [7:0]        I_PADDR,     // apb byte address
  input  wire logic [31:0]       I_PWDATA,    // apb write data
  output logic      [31:0]       O_PRDATA,    // apb read data
  output logic                   O_PREADY,    // apb ready
  output logic                   O_PSLVERR,   // apb error, unmapped
  input  wire logic [15:0]       I_VOUT_MV,   // measured output, mv
  input  wire logic [15:0]       I_VSET_MV,   // output setpoint, mv
  input  wire logic [15:0]       I_VTRACK_MV, // ramp reference, mv
  input  wire logic              I_RAMP_UP,   // ramp generator rising
  input  wire logic signed [7:0] I_TEMP_C,    // junction temp, deg c
  output logic                   O_TURN_OFF,  // turn-off to core
  output logic                   O_OT_WARN,   // overtemp warning
  output logic                   O_OUTPUT_IN_WINDOW_FLAG, // power good
  output logic                   O_IRQ        // level interrupt
);

  typedef struct packed {
    logic [5:0]  ctrl;
    logic [1:0]  uv_sel;
    logic [1:0]  ov_sel;
    logic        pg_sel;
    logic [5:0]  irq_st;
    logic [5:0]  irq_mk;
    logic        ot_off;
    logic        ot_q_d;
    logic        warn_raw;
    logic        warn_d;
    logic        pg_d;
    logic        turn_off;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } st_s;

  st_s         st_ff;
  st_s         nxt_st;
  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic [15:0] uv_mv;
  logic [15:0] ov_mv;
  logic [15:0] ov_pct_mv;
  logic [15:0] pg_lo_mv;
  logic [15:0] pg_hi_mv;
  logic [7:0]  uv_pct;
  logic [7:0]  ov_pct;
  logic [7:0]  pg_pct;
  logic [15:0] trk_dev;
  logic        drive_on;
  logic        uv_raw;
  logic        ov_raw;
  logic        trk_raw;
  logic        pg_raw;
  logic        uv_q;
  logic        ov_q;
  logic        trk_q;
  logic        ot_q;
  logic        warn_q;
  logic        pg_q;
  logic        uv_off;
  logic        ov_off;
  logic        trk_off;
  logic        uv_trip;
  logic        ov_trip;
  logic        trk_trip;
  logic        rearm;
  logic        apb_done;
  logic        wr_ctrl;
  logic [5:0]  events;

  // reset release through two flip-flops
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // programmed trip levels from percentages of the setpoint
  always_comb
  begin
    uv_pct = fault_sup_pkg::UV_BASE_PCT
           + 8'(st_ff.uv_sel) * fault_sup_pkg::UV_STEP_PCT;
    if (st_ff.ov_sel == 2'h3)
      ov_pct = fault_sup_pkg::OV_MIN_PCT;
    else
      ov_pct = fault_sup_pkg::OV_BASE_PCT
             - 8'(st_ff.ov_sel) * fault_sup_pkg::OV_STEP_PCT;
    pg_pct = fault_sup_pkg::PG_LO_PCT
           + 8'(st_ff.pg_sel) * fault_sup_pkg::PG_STEP_PCT;
  end

  assign uv_mv     = fault_sup_pkg::pct_of(I_VSET_MV, uv_pct);
  assign ov_pct_mv = fault_sup_pkg::pct_of(I_VSET_MV, ov_pct);
  assign pg_lo_mv  = fault_sup_pkg::pct_of(I_VSET_MV, pg_pct);
  assign pg_hi_mv  = fault_sup_pkg::pct_of(I_VSET_MV,
                                           fault_sup_pkg::PG_HI_PCT);
  // overvoltage level floored at 1.0 v
  assign ov_mv = (ov_pct_mv < fault_sup_pkg::OV_FLOOR_MV)
               ? fault_sup_pkg::OV_FLOOR_MV : ov_pct_mv;

  // raw comparisons; undervoltage is ignored while off or ramping
  assign drive_on = ~st_ff.turn_off;
  assign uv_raw   = drive_on & ~I_RAMP_UP & (I_VOUT_MV < uv_mv);
  assign ov_raw   = drive_on & (I_VOUT_MV > ov_mv);
  assign trk_dev  = (I_VOUT_MV > I_VTRACK_MV) ? I_VOUT_MV - I_VTRACK_MV
                                              : I_VTRACK_MV - I_VOUT_MV;
  assign trk_raw  = drive_on & I_RAMP_UP
                  & st_ff.ctrl[fault_sup_pkg::CTRL_TRK_EN]
                  & (trk_dev > fault_sup_pkg::TRK_BAND_MV);
  assign pg_raw   = (I_VOUT_MV >= pg_lo_mv)
                  & (I_VOUT_MV <= pg_hi_mv);

  // 6 us qualification of voltage faults, warning and window
  persist_filter #(.N(fault_sup_pkg::FAULT_DLY_CYC), .INIT(1'b0)) u_uv_flt
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_raw   (uv_raw),
    .o_q     (uv_q)
  );

  persist_filter #(.N(fault_sup_pkg::FAULT_DLY_CYC), .INIT(1'b0)) u_ov_flt
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_raw   (ov_raw),
    .o_q     (ov_q)
  );

  persist_filter #(.N(fault_sup_pkg::FAULT_DLY_CYC), .INIT(1'b0)) u_trk_flt
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_raw   (trk_raw),
    .o_q     (trk_q)
  );

  persist_filter #(.N(fault_sup_pkg::FAULT_DLY_CYC), .INIT(1'b0)) u_warn_flt
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_raw   (st_ff.warn_raw),
    .o_q     (warn_q)
  );

  persist_filter #(.N(fault_sup_pkg::FAULT_DLY_CYC), .INIT(1'b0)) u_pg_flt
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_raw   (pg_raw),
    .o_q     (pg_q)
  );

  // 2 ms qualification of overtemperature
  persist_filter #(.N(OT_DLY_CYC), .INIT(1'b0)) u_ot_flt
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_raw   (I_TEMP_C >= fault_sup_pkg::OT_OFF_C),
    .o_q     (ot_q)
  );

  // fault responses, latching or periodic retry
  fault_responder #(.RETRY_CYC(RETRY_CYC)) u_uv_rsp
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_fault (uv_q),
    .i_latch (st_ff.ctrl[fault_sup_pkg::CTRL_UV_LATCH]),
    .i_rearm (rearm),
    .o_off   (uv_off),
    .o_trip  (uv_trip)
  );

  fault_responder #(.RETRY_CYC(RETRY_CYC)) u_ov_rsp
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_fault (ov_q),
    .i_latch (st_ff.ctrl[fault_sup_pkg::CTRL_OV_LATCH]),
    .i_rearm (rearm),
    .o_off   (ov_off),
    .o_trip  (ov_trip)
  );

  fault_responder #(.RETRY_CYC(RETRY_CYC)) u_trk_rsp
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_n),
    .i_fault (trk_q),
    .i_latch (st_ff.ctrl[fault_sup_pkg::CTRL_TRK_LATCH]),
    .i_rearm (rearm),
    .o_off   (trk_off),
    .o_trip  (trk_trip)
  );

  // apb transfer completes on the second access cycle
  assign apb_done = I_PSEL & I_PENABLE & st_ff.pready;
  assign wr_ctrl  = apb_done & I_PWRITE
                  & (I_PADDR == fault_sup_pkg::ADDR_CTRL);
  // turning the enable bit from 0 to 1 re-enables latched faults
  assign rearm = wr_ctrl & I_PWDATA[fault_sup_pkg::CTRL_EN_BIT]
               & ~st_ff.ctrl[fault_sup_pkg::CTRL_EN_BIT];

  // interrupt events
  assign events = {pg_q != st_ff.pg_d,
                   warn_q & ~st_ff.warn_d,
                   ot_q & ~st_ff.ot_q_d,
                   trk_trip, ov_trip, uv_trip};

  // next state: registers, protection state and outputs
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.ot_q_d  = ot_q;
    nxt_st.warn_d  = warn_q;
    nxt_st.pg_d    = pg_q;
    nxt_st.pready  = I_PSEL & I_PENABLE & ~st_ff.pready;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata  = 32'h0000_0000;

    // warning hysteresis, always active
    if (I_TEMP_C > fault_sup_pkg::OT_OFF_C)
      nxt_st.warn_raw = 1'b1;
    else if (I_TEMP_C < fault_sup_pkg::WARN_CLR_C)
      nxt_st.warn_raw = 1'b0;

    // overtemperature shutdown and restart at 110 c falling
    if (ot_q & ~st_ff.ot_q_d)
      nxt_st.ot_off = 1'b1;
    else if (st_ff.ot_off & (I_TEMP_C <= fault_sup_pkg::OT_ON_C)
             & (~st_ff.ctrl[fault_sup_pkg::CTRL_OT_LATCH] | rearm))
      nxt_st.ot_off = 1'b0;

    // read data and error answer, loaded as pready rises
    if (I_PSEL & I_PENABLE & ~st_ff.pready)
    begin
      case (I_PADDR)
        fault_sup_pkg::ADDR_CTRL:
          nxt_st.prdata = {26'h0, st_ff.ctrl};
        fault_sup_pkg::ADDR_THRESH:
          nxt_st.prdata = {23'h0, st_ff.pg_sel, 2'h0, st_ff.ov_sel,
                           2'h0, st_ff.uv_sel};
        fault_sup_pkg::ADDR_STATUS:
          nxt_st.prdata = {24'h0, st_ff.ot_off, trk_off, ov_off, uv_off,
                           st_ff.turn_off, O_OUTPUT_IN_WINDOW_FLAG,
                           O_OT_WARN, st_ff.warn_raw};
        fault_sup_pkg::ADDR_IRQ_ST:
          nxt_st.prdata = {26'h0, st_ff.irq_st};
        fault_sup_pkg::ADDR_IRQ_MK:
          nxt_st.prdata = {26'h0, st_ff.irq_mk};
        default:
          nxt_st.pslverr = 1'b1;
      endcase
    end

    // register writes at the completing edge
    if (apb_done & I_PWRITE)
    begin
      case (I_PADDR)
        fault_sup_pkg::ADDR_CTRL:
          nxt_st.ctrl = I_PWDATA[fault_sup_pkg::CTRL_W-1:0];
        fault_sup_pkg::ADDR_THRESH:
        begin
          nxt_st.uv_sel = I_PWDATA[fault_sup_pkg::UV_SEL_LSB +: 2];
          nxt_st.ov_sel = I_PWDATA[fault_sup_pkg::OV_SEL_LSB +: 2];
          nxt_st.pg_sel = I_PWDATA[fault_sup_pkg::PG_SEL_BIT];
        end
        fault_sup_pkg::ADDR_IRQ_MK:
          nxt_st.irq_mk = I_PWDATA[fault_sup_pkg::IRQ_W-1:0];
        default:
          nxt_st.irq_mk = st_ff.irq_mk;
      endcase
    end

    // sticky status: read clears, a new event wins
    if (apb_done & ~I_PWRITE & (I_PADDR == fault_sup_pkg::ADDR_IRQ_ST))
      nxt_st.irq_st = events;
    else
      nxt_st.irq_st = st_ff.irq_st | events;
    nxt_st.irq = |(st_ff.irq_st & st_ff.irq_mk);

    // turn-off request to the conversion core
    nxt_st.turn_off = ~st_ff.ctrl[fault_sup_pkg::CTRL_EN_BIT]
                    | uv_off | ov_off | trk_off
                    | nxt_st.ot_off;
  end

  always_ff @(posedge I_CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff         <= '0;
      st_ff.ctrl    <= fault_sup_pkg::CTRL_RST;
      st_ff.uv_sel  <= fault_sup_pkg::UV_SEL_RST;
      st_ff.ov_sel  <= fault_sup_pkg::OV_SEL_RST;
      st_ff.pg_sel  <= fault_sup_pkg::PG_SEL_RST;
      st_ff.irq_mk  <= fault_sup_pkg::IRQ_MASK_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from flip-flops
  assign O_PRDATA                = st_ff.prdata;
  assign O_PREADY                = st_ff.pready;
  assign O_PSLVERR               = st_ff.pslverr;
  assign O_TURN_OFF              = st_ff.turn_off;
  assign O_OT_WARN               = st_ff.warn_d;
  assign O_OUTPUT_IN_WINDOW_FLAG = st_ff.pg_d;
  assign O_IRQ                   = st_ff.irq;
endmodule // output_fault_supervisor

// File: logic/persist_filter.sv
`timescale 1ns/1ps
// output follows the input once the input held its new level n cycles
module persist_filter #(
  parameter int   N    = 750,
  parameter logic INIT = 1'b0
) (
  input  wire logic i_clk,    // system clock
  input  wire logic i_rst_n,  // synchronised reset, active low
  input  wire logic i_raw,    // raw condition
  output logic      o_q       // qualified condition
);
  localparam int CW = $clog2(N + 1);

  typedef struct packed {
    logic          q;
    logic [CW-1:0] cnt;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  // count persistence of a differing level, reset on agreement
  always_comb
  begin
    nxt_st = st_ff;
    if (i_raw == st_ff.q)
      nxt_st.cnt = '0;
    else if (st_ff.cnt == CW'(N - 1))
    begin
      nxt_st.q   = i_raw;
      nxt_st.cnt = '0;
    end
    else
      nxt_st.cnt = st_ff.cnt + CW'(1);
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_ff <= '{q: INIT, cnt: '0};
    else
      st_ff <= nxt_st;
  end

  assign o_q = st_ff.q;
endmodule // persist_filter

// File: testbench/ofs_checker.sv
`timescale 1ns/1ps
// watches the supervisor ports for bus and protection timing
module ofs_checker #(
  parameter int OT_DLY_CYC = 250000
) (
  input  wire logic              I_CLK_SYS,   // clock
  input  wire logic              I_RESET_N,   // reset, active low
  input  wire logic              I_PSEL,      // apb select
  input  wire logic              I_PENABLE,   // apb access
  input  wire logic [31:0]       O_PRDATA,    // apb read data
  input  wire logic              O_PREADY,    // apb ready
  input  wire logic              O_PSLVERR,   // apb error
  input  wire logic [15:0]       I_VOUT_MV,   // output mv
  input  wire logic [15:0]       I_VSET_MV,   // setpoint mv
  input  wire logic              I_RAMP_UP,   // ramping up
  input  wire logic signed [7:0] I_TEMP_C,    // junction temp
  input  wire logic              O_TURN_OFF,  // turn-off
  input  wire logic              O_OT_WARN,   // warning
  input  wire logic              O_OUTPUT_IN_WINDOW_FLAG // power good
);
  typedef struct packed {
    logic [19:0] uv, ov, ot, hot, cold, inw, outw;
  } run_s;
  run_s        run_ff;
  run_s        nxt_run;
  logic [31:0] v100;
  logic [31:0] vs;

  function automatic logic [19:0] step(input logic c, input logic [19:0] n);
    return c ? n + 20'h1 : 20'h0;
  endfunction

  // scaled voltages so percent levels compare without division
  assign v100 = {16'h0000, I_VOUT_MV} * 32'h64;
  assign vs   = {16'h0000, I_VSET_MV};

  // consecutive-cycle counters of each condition
  always_comb
  begin
    nxt_run.uv   = step(v100 < vs * 32'h4B && !I_RAMP_UP && !O_TURN_OFF,
                        run_ff.uv);
    nxt_run.ov   = step(v100 > vs * 32'h82 && I_VOUT_MV > 16'h03E8
                        && !O_TURN_OFF, run_ff.ov);
    nxt_run.ot   = step(I_TEMP_C >= 8'sh78 && !O_TURN_OFF, run_ff.ot);
    nxt_run.hot  = step(I_TEMP_C > 8'sh78, run_ff.hot);
    nxt_run.cold = step(I_TEMP_C < 8'sh75, run_ff.cold);
    nxt_run.inw  = step(v100 >= vs * 32'h5F && v100 <= vs * 32'h6E,
                        run_ff.inw);
    nxt_run.outw = step(v100 < vs * 32'h5A || v100 > vs * 32'h6E,
                        run_ff.outw);
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
    if (!I_RESET_N)
      run_ff <= '0;
    else
      run_ff <= nxt_run;

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RESET_N);

  sequence s_access;
    I_PSEL && I_PENABLE && !O_PREADY;
  endsequence
  sequence s_answer;
    O_PREADY ##1 !O_PREADY;
  endsequence

  a_apb_wait: assert property (s_access |=> s_answer)
    else $error("ready not one pulse after one wait");
  a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  a_rdata_idle: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside ready");
  a_uv_delay: assert property (run_ff.uv < 20'h2F8)
    else $error("undervoltage turn-off late");
  a_ov_delay: assert property (run_ff.ov < 20'h2F8)
    else $error("overvoltage turn-off late");
  a_ot_delay: assert property (run_ff.ot < 20'(OT_DLY_CYC + 8))
    else $error("overtemperature turn-off late");
  a_warn_set: assert property (run_ff.hot >= 20'h2F8 |-> O_OT_WARN)
    else $error("warning missing");
  a_warn_early: assert property ($rose(O_OT_WARN) |-> run_ff.hot >= 20'h2EE)
    else $error("warning too early");
  a_warn_clear: assert property (run_ff.cold >= 20'h2F8 |-> !O_OT_WARN)
    else $error("warning not cleared");
  a_window_in: assert property (run_ff.inw >= 20'h2F8
    |-> O_OUTPUT_IN_WINDOW_FLAG)
    else $error("power good low inside window");
  a_window_out: assert property (run_ff.outw >= 20'h2F8
    |-> !O_OUTPUT_IN_WINDOW_FLAG)
    else $error("power good high outside window");
endmodule // ofs_checker

bind output_fault_supervisor ofs_checker #(.OT_DLY_CYC(OT_DLY_CYC))
  u_ofs_checker (.*);

// File: testbench/output_fault_supervisor_tb.sv
`timescale 1ns/1ps
module output_fault_supervisor_tb;
  localparam int ST = 760; // settle time after a filtered change
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [15:0]       vout = 16'h03E8;
  logic [15:0]       vset = 16'h03E8;
  logic [15:0]       vtrk = 16'h03E8;
  logic              ramp = 1'b0;
  logic signed [7:0] temp = 8'sh19;
  logic [31:0]       prdata, r;
  logic              pready, pslverr, off, warn, pg, irq, h_pg;
  logic [15:0]       h_chg, chg0;
  logic [33:0]       expq[$];
  logic [33:0]       e;
  int                n_errors = 0;
  int                n_tests = 0;
  int                seed = 38;

  always #4 clk = ~clk;

  output_fault_supervisor #(.OT_DLY_CYC(20), .RETRY_CYC(30)) DUT (
    .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_VOUT_MV(vout), .I_VSET_MV(vset),
    .I_VTRACK_MV(vtrk), .I_RAMP_UP(ramp), .I_TEMP_C(temp),
    .O_TURN_OFF(off), .O_OT_WARN(warn),
    .O_OUTPUT_IN_WINDOW_FLAG(pg), .O_IRQ(irq));

  pg_host_model u_host (.i_clk(clk), .i_rst_n(rst_n), .i_pg(pg),
    .o_pg(h_pg), .o_n_chg(h_chg));

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // read: note the expected {error, data} first, c=0 means ignore
  task automatic rd(input logic [7:0] a, input logic [32:0] x, input logic c);
    expq.push_back({c, x});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  // compare each completed read with the oldest note
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = expq.pop_front();
      if (e[33])
        chk_word({pslverr, prdata}, e[32:0]);
    end

  initial
  begin
    hold(10);
    rst_n <= 1'b1;
    hold(3);
    rd(fault_sup_pkg::ADDR_CTRL, {27'h0, fault_sup_pkg::CTRL_RST}, 1);
    rd(fault_sup_pkg::ADDR_THRESH, 33'h0, 1);
    rd(fault_sup_pkg::ADDR_IRQ_MK, 33'h0, 1);
    rd(8'h14, 33'h1_0000_0000, 1);
    r = 32'($random(seed)) & 32'h3F;
    wr(fault_sup_pkg::ADDR_IRQ_MK, r);
    rd(fault_sup_pkg::ADDR_IRQ_MK, {1'b0, r}, 1);
    wr(fault_sup_pkg::ADDR_IRQ_MK, 32'h0);
    done("registers");
    hold(ST);
    chk_bit(pg, 1'b1);
    vout <= 16'h044C;
    hold(ST);
    chk_bit(pg, 1'b1);
    chg0 = h_chg;
    vout <= 16'h044D;
    hold(740);
    chk_bit(pg, 1'b1);
    hold(20);
    chk_bit(pg, 1'b0);
    chk_word({17'h0, h_chg}, {17'h0, chg0 + 16'h1});
    vout <= 16'h0384;
    hold(ST);
    chk_bit(pg, 1'b1);
    wr(fault_sup_pkg::ADDR_THRESH, 32'h100);
    hold(ST);
    chk_bit(pg, 1'b0);
    wr(fault_sup_pkg::ADDR_THRESH, 32'h0);
    vout <= 16'h03B6 + 16'($random(seed) & 32'h7F);
    hold(ST);
    chk_bit(pg, 1'b1);
    chk_bit(irq, 1'b0);
    done("window");
    rd(fault_sup_pkg::ADDR_IRQ_ST, 33'h0, 0);
    wr(fault_sup_pkg::ADDR_IRQ_MK, 32'h1);
    vout <= 16'h02BC;
    hold(ST);
    chk_bit(off, 1'b1);
    chk_bit(irq, 1'b1);
    rd(fault_sup_pkg::ADDR_IRQ_ST, 33'h21, 1);
    vout <= 16'h03E8;
    hold(2 * ST);
    chk_bit(off, 1'b0);
    rd(fault_sup_pkg::ADDR_IRQ_ST, 33'h0, 0);
    hold(3);
    chk_bit(irq, 1'b0);
    wr(fault_sup_pkg::ADDR_THRESH, 32'h3);
    wr(fault_sup_pkg::ADDR_CTRL, 32'h3);
    vout <= 16'h0370;
    hold(ST);
    chk_bit(off, 1'b1);
    vout <= 16'h03E8;
    hold(ST);
    chk_bit(off, 1'b1);
    wr(fault_sup_pkg::ADDR_CTRL, 32'h2);
    wr(fault_sup_pkg::ADDR_CTRL, 32'h3);
    hold(10);
    chk_bit(off, 1'b0);
    wr(fault_sup_pkg::ADDR_THRESH, 32'h0);
    wr(fault_sup_pkg::ADDR_CTRL, 32'h1);
    done("undervoltage");
    vset <= 16'h01F4;
    vout <= 16'h0384;
    hold(ST);
    chk_bit(off, 1'b0);
    vout <= 16'h044C;
    hold(ST);
    chk_bit(off, 1'b1);
    vout <= 16'h01F4;
    hold(2 * ST);
    chk_bit(off, 1'b0);
    // latching overvoltage: stays off until the enable bit is toggled
    wr(fault_sup_pkg::ADDR_CTRL, 32'h5);
    vout <= 16'h044C;
    hold(ST);
    chk_bit(off, 1'b1);
    vout <= 16'h01F4;
    hold(2 * ST);
    chk_bit(off, 1'b1);
    wr(fault_sup_pkg::ADDR_CTRL, 32'h4);
    wr(fault_sup_pkg::ADDR_CTRL, 32'h5);
    hold(10);
    chk_bit(off, 1'b0);
    wr(fault_sup_pkg::ADDR_CTRL, 32'h1);
    vset <= 16'h03E8;
    vout <= 16'h03E8;
    done("overvoltage");
    ramp <= 1'b1;
    vout <= 16'h04EC;
    hold(ST);
    chk_bit(off, 1'b0);
    vout <= 16'h04D8;
    wr(fault_sup_pkg::ADDR_CTRL, 32'h9);
    hold(ST);
    chk_bit(off, 1'b0);
    vout <= 16'h04EC;
    hold(ST);
    chk_bit(off, 1'b1);
    ramp <= 1'b0;
    vout <= 16'h03E8;
    wr(fault_sup_pkg::ADDR_CTRL, 32'h1);
    hold(2 * ST);
    chk_bit(off, 1'b0);
    done("tracking");
    temp <= 8'sh79;
    hold(30);
    chk_bit(off, 1'b1);
    chk_bit(warn, 1'b0);
    hold(ST);
    chk_bit(warn, 1'b1);
    temp <= 8'sh76;
    hold(ST);
    chk_bit(off, 1'b1);
    chk_bit(warn, 1'b1);
    temp <= 8'sh6E;
    hold(10);
    chk_bit(off, 1'b0);
    temp <= 8'sh74;
    hold(ST);
    chk_bit(warn, 1'b0);
    done("overtemperature");
    wrap_up();
  end
endmodule // output_fault_supervisor_tb

// File: testbench/pg_host_model.sv
`timescale 1ns/1ps
// host side: samples the power-good output and counts its changes
module pg_host_model (
  input  wire logic        i_clk,   // system clock
  input  wire logic        i_rst_n, // reset, active low
  input  wire logic        i_pg,    // power-good from the block
  output logic             o_pg,    // sampled level
  output logic      [15:0] o_n_chg  // changes seen
);
  // sample once a cycle, count level changes
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_pg    <= 1'b0;
      o_n_chg <= 16'h0000;
    end
    else
    begin
      o_pg <= i_pg;
      if (i_pg != o_pg)
        o_n_chg <= o_n_chg + 16'h0001;
    end
endmodule // pg_host_model
